// ===== hdl/vnr_pkg.sv
// Purpose: shared constants and carriers for the valve node transmit scheduler
// Assumes: 200 MHz ref_clk, CAN frame engine outside consumes one tx request at a time
// Notes: identifiers are 11-bit base plus node id
`default_nettype none
package vnr_pkg;
	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int unsigned CLK_MHZ = 200; // ref_clk rate
	localparam int unsigned SLOW_TICK_MS = 2; // slow tx spacing
	localparam int unsigned SLOW_TICK_CYC = SLOW_TICK_MS * 1000 * CLK_MHZ;
	localparam int unsigned LINK_TMO_MS = 40; // typical sync/fast timeout
	localparam int unsigned LINK_TMO_CYC = LINK_TMO_MS * 1000 * CLK_MHZ;
	// ------------------------------------------------------------
	// identifiers
	// ------------------------------------------------------------
	localparam logic [10:0] ID_FAST = 11'h180;
	localparam logic [10:0] ID_TEMP = 11'h280;
	localparam logic [10:0] ID_VOLT = 11'h380;
	localparam logic [10:0] ID_POS = 11'h480;
	localparam logic [10:0] ID_CURF = 11'h1E0;
	localparam logic [10:0] ID_FLG0 = 11'h2E0;
	localparam logic [10:0] ID_FLG4 = 11'h3E0;
	localparam logic [10:0] ID_FLG8 = 11'h4E0;
	localparam logic [10:0] ID_RX_SLOW1 = 11'h300; // first slow parameter message
	localparam logic [10:0] ID_RX_SLOW5 = 11'h260; // first of the second slow rx group
	localparam logic [10:0] ID_RX_SLOW8 = 11'h560; // last slow parameter message
	localparam logic [10:0] ID_RX_FAST = 11'h200;
	localparam logic [10:0] ID_SDO_RX = 11'h600; // sdo request from master
	localparam logic [10:0] ID_SDO_TX = 11'h580; // sdo reply to master
	localparam logic [2:0] SLOW_LAST = 3'h6; // index of last slow pdo (7 of them)
	localparam logic [3:0] FAST_DLC = 4'h5;
	localparam logic [3:0] FULL_DLC = 4'h8;
	localparam logic [7:0] SDO_ABORT_CS = 8'h80; // abort transfer command
	localparam logic [31:0] SDO_ERR_RO = 32'h06010002; // object is read only
	// ------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic [10:0] id;
		logic [3:0] dlc;
		logic [63:0] data; // byte 0 in [7:0]
	} vnr_frame_s;
	typedef struct packed {
		logic [15:0] act_pos;
		logic [15:0] act_cur;
		logic [5:0] stat;
		logic [31:0] drv_temp;
		logic [31:0] in_cur;
		logic [31:0] in_v1;
		logic [31:0] in_v2;
		logic [31:0] pos1;
		logic [31:0] pos2;
		logic [31:0] cur_filt;
		logic [13:0][15:0] flags; // status error flag words 0..13
	} vnr_status_s;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_SEND = 2'b01, // one bit from idle and from wait
		ST_WAIT = 2'b11
	} vnr_seq_e;
endpackage : vnr_pkg
`default_nettype wire

// ===== hdl/vnr_slow_payload.sv
// Purpose: builds one slow transmit pdo frame by sequence index
// Assumes: index 0..6 covers the seven slow pdos in send order
// Notes: purely combinational, unused bytes are zero
`default_nettype none
module vnr_slow_payload
	import vnr_pkg::*;
(
	input wire logic [2:0] idx,
	input wire logic [6:0] node_id,
	input wire vnr_status_s st,
	output vnr_frame_s frm
);
	// ------------------------------------------------------------
	// payload mux
	// ------------------------------------------------------------
	always_comb begin
		frm = '0;
		frm.dlc = FULL_DLC;
		case (idx)
			3'h0: begin // temperature and input current
				frm.id = ID_TEMP;
				frm.data = {st.in_cur, st.drv_temp};
			end
			3'h1: begin // two input voltages
				frm.id = ID_VOLT;
				frm.data = {st.in_v2, st.in_v1};
			end
			3'h2: begin // two actual positions
				frm.id = ID_POS;
				frm.data = {st.pos2, st.pos1};
			end
			3'h3: begin // filtered current, bytes 4-7 unused
				frm.id = ID_CURF;
				frm.data = {32'h0, st.cur_filt};
			end
			3'h4: begin // flag words 0..3
				frm.id = ID_FLG0;
				frm.data = {st.flags[3], st.flags[2], st.flags[1], st.flags[0]};
			end
			3'h5: begin // flag words 4, 5, 13, blank tail
				frm.id = ID_FLG4;
				frm.data = {16'h0, st.flags[13], st.flags[5], st.flags[4]};
			end
			3'h6: begin // flag words 8, 9, 10
				frm.id = ID_FLG8;
				frm.data = {16'h0, st.flags[10], st.flags[9], st.flags[8]};
			end
			default: begin
				frm.id = ID_TEMP;
			end
		endcase
		frm.id = frm.id + {4'h0, node_id};
	end
endmodule : vnr_slow_payload
`default_nettype wire

// ===== hdl/vnr_responder.sv
// Purpose: valve node transmit scheduler, fast and slow pdo framing
// Assumes: rx frames arrive as one-cycle valid pulses from a can controller
// Notes: tx is one frame held until tx_ready accepts it
// What this block does
// - no slow tx before first slow rx
// - first slow rx starts full slow sequence
// - slow frames spaced on 2 ms tick
// - any slow parameter rx sets params_rx_q
// - fast pdo position, current, status bits
// - pdo 0x2E0 carries flag words 0-3
// - pdo 0x3E0 carries words 4,5,13
// - pdo 0x4E0 carries words 8,9,10
// - sdo parameter writes are rejected
// - sync applies demand, sends fast pdo
// - flag failure on sync/fast timeout
`default_nettype none
module vnr_responder
	import vnr_pkg::*;
#(
	parameter int unsigned TICK_CYC = SLOW_TICK_CYC, // shortenable for simulation
	parameter int unsigned TMO_CYC = LINK_TMO_CYC // shortenable for simulation
) (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic [6:0] node_id,
	input wire logic rx_valid,
	input wire vnr_frame_s rx_frame,
	input wire logic sync_rx,
	input wire vnr_status_s status,
	input wire logic tx_ready,
	output logic tx_valid,
	output vnr_frame_s tx_frame,
	output logic [31:0] demand_q,
	output logic params_rx_q,
	output logic comm_fail_q
);
	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	// refused at elaboration, the pacing compare needs a count of two or more
	if (TICK_CYC < 2 || TMO_CYC < 2) begin : g_bad_count
		$error("tick and timeout counts must be at least 2");
	end

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		vnr_seq_e seq; // slow sequence state
		logic [2:0] idx; // next slow pdo index
		logic [31:0] tick; // 2 ms pacing counter
		logic [31:0] tmo; // link timeout counter
		logic fast_seen; // fast demand since last check
		logic sync_seen; // sync since last check
		logic [31:0] pend; // latest fast demand, not yet applied
		logic [31:0] demand; // applied demand
		logic params; // any slow parameter seen
		logic fail; // communication failure
		logic fast_pend; // fast pdo owed after sync
		logic sdo_pend; // abort reply owed
		logic [15:0] sdo_idx; // index of rejected object
		logic [7:0] sdo_sub;
		logic txv;
		vnr_frame_s txf;
	} vnr_state_s;

	vnr_state_s s_q; // registered state
	vnr_state_s s_d; // next state
	vnr_frame_s slow_frm; // current slow payload
	logic [10:0] rx_base; // rx id minus node id
	logic rx_fast; // fast demand frame for this node
	logic rx_slow; // any slow parameter frame for this node
	logic sdo_wr; // sdo download request, always refused

	vnr_slow_payload u_pay (
		.idx(s_q.idx),
		.node_id(node_id),
		.st(status),
		.frm(slow_frm)
	);

	assign rx_base = rx_frame.id - {4'h0, node_id};
	assign rx_fast = rx_valid && rx_base == ID_RX_FAST;
	// slow rx ids form two groups, low byte 00 from 0x300 and low byte 60 from 0x260
	assign rx_slow = rx_valid && ((rx_base[7:0] == ID_RX_SLOW1[7:0] &&
		rx_base[10:8] >= ID_RX_SLOW1[10:8] && rx_base[10:8] <= ID_RX_SLOW8[10:8]) ||
		(rx_base[7:0] == ID_RX_SLOW5[7:0] && rx_base[10:8] >= ID_RX_SLOW5[10:8] &&
		rx_base[10:8] <= ID_RX_SLOW8[10:8]));
	assign sdo_wr = rx_valid && rx_base == ID_SDO_RX && rx_frame.data[7:5] == 3'h1;

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		// accepted frame drops, so a new one can be loaded
		if (s_q.txv && tx_ready) begin
			s_d.txv = 1'b0;
		end
		// receive decode
		if (rx_valid) begin
			if (rx_fast) begin
				s_d.pend = rx_frame.data[31:0]; // held until sync
				s_d.fast_seen = 1'b1;
			end
			if (rx_slow) begin
				s_d.params = 1'b1;
			end
			// only the first slow message opens a sequence; repeats mid-run ignored
			if (rx_base == ID_RX_SLOW1 && s_q.seq == ST_IDLE) begin
				s_d.seq = ST_SEND;
				s_d.idx = 3'h0;
			end
			if (sdo_wr) begin
				s_d.sdo_pend = 1'b1;
				s_d.sdo_idx = rx_frame.data[23:8];
				s_d.sdo_sub = rx_frame.data[31:24];
			end
		end
		if (sync_rx) begin
			s_d.demand = s_q.pend;
			s_d.fast_pend = 1'b1;
			s_d.sync_seen = 1'b1;
		end
		// link supervision window
		if (s_q.tmo == TMO_CYC - 1) begin
			s_d.tmo = '0;
			s_d.fail = !(s_q.fast_seen && s_q.sync_seen);
			// an event on the closing edge counts for the next window
			s_d.fast_seen = rx_fast;
			s_d.sync_seen = sync_rx;
		end else begin
			s_d.tmo = s_q.tmo + 32'h1;
		end
		// slow pacing
		case (s_q.seq)
			ST_IDLE: begin
				s_d.tick = '0;
			end
			ST_WAIT: begin
				if (s_q.tick >= TICK_CYC - 1) begin
					s_d.seq = ST_SEND;
				end else begin
					s_d.tick = s_q.tick + 32'h1;
				end
			end
			ST_SEND: begin
				s_d.tick = s_q.tick + 32'h1; // tick runs from previous launch
			end
			default: begin
				s_d.seq = ST_IDLE;
			end
		endcase
		// transmit arbiter: fast first, then sdo, then slow
		if (!s_d.txv) begin
			if (s_q.fast_pend) begin
				s_d.fast_pend = sync_rx; // a sync on this edge still owes a reply
				s_d.txv = 1'b1;
				s_d.txf.id = ID_FAST + {4'h0, node_id};
				s_d.txf.dlc = FAST_DLC;
				s_d.txf.data = {24'h0, 2'b00, status.stat, status.act_cur,
					status.act_pos};
			end else if (s_q.sdo_pend) begin
				s_d.sdo_pend = sdo_wr; // a request on this edge is not lost
				s_d.txv = 1'b1;
				s_d.txf.id = ID_SDO_TX + {4'h0, node_id};
				s_d.txf.dlc = FULL_DLC;
				s_d.txf.data = {SDO_ERR_RO, s_q.sdo_sub, s_q.sdo_idx,
					SDO_ABORT_CS};
			end else if (s_q.seq == ST_SEND) begin
				s_d.txv = 1'b1;
				s_d.txf = slow_frm;
				s_d.tick = '0;
				if (s_q.idx == SLOW_LAST) begin
					s_d.seq = ST_IDLE;
				end else begin
					s_d.idx = s_q.idx + 3'h1;
					s_d.seq = ST_WAIT;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign tx_valid = s_q.txv;
	assign tx_frame = s_q.txf;
	assign demand_q = s_q.demand;
	assign params_rx_q = s_q.params;
	assign comm_fail_q = s_q.fail;

	// ------------------------------------------------------------
	// checks on behaviour
	// ------------------------------------------------------------
	a_no_early_slow: assert property (@(posedge ref_clk) disable iff (sys_rst)
		!s_q.params |-> !(tx_valid && (tx_frame.id == ID_TEMP + {4'h0, node_id} ||
		tx_frame.id == ID_FLG8 + {4'h0, node_id})))
		else $error("slow pdo sent before parameters");
	a_seq_start: assert property (@(posedge ref_clk) disable iff (sys_rst)
		rx_valid && rx_base == ID_RX_SLOW1 && s_q.seq == ST_IDLE |=> s_q.seq != ST_IDLE)
		else $error("slow sequence did not start");
	a_tick_space: assert property (@(posedge ref_clk) disable iff (sys_rst)
		s_q.seq == ST_WAIT && $past(s_q.seq) == ST_SEND |-> s_q.tick <= 32'h1)
		else $error("slow tick not restarted");
	a_param_flag: assert property (@(posedge ref_clk) disable iff (sys_rst)
		rx_valid && rx_base == ID_RX_SLOW1 |=> params_rx_q)
		else $error("parameter flag not set");
	a_sync_apply: assert property (@(posedge ref_clk) disable iff (sys_rst)
		sync_rx |=> demand_q == $past(s_q.pend))
		else $error("demand not applied on sync");
	// sdo or slow loads on the sync edge would rightly push the fast reply back
	a_fast_reply: assert property (@(posedge ref_clk) disable iff (sys_rst)
		sync_rx && !s_q.txv && !s_q.fast_pend && !s_q.sdo_pend && s_q.seq != ST_SEND |=>
		##1 tx_valid && tx_frame.id == ID_FAST + {4'h0, node_id} &&
		tx_frame.dlc == FAST_DLC)
		else $error("fast pdo missing after sync");
	a_fast_pad: assert property (@(posedge ref_clk) disable iff (sys_rst)
		tx_valid && tx_frame.id == ID_FAST + {4'h0, node_id} |-> tx_frame.data[63:38] == '0)
		else $error("fast pdo unused bits set");
	a_sdo_reject: assert property (@(posedge ref_clk) disable iff (sys_rst)
		tx_valid && tx_frame.id == ID_SDO_TX + {4'h0, node_id} |->
		tx_frame.data[7:0] == SDO_ABORT_CS)
		else $error("sdo write not aborted");
	a_link_fail: assert property (@(posedge ref_clk) disable iff (sys_rst)
		s_q.tmo == TMO_CYC - 1 && !s_q.sync_seen |=> comm_fail_q)
		else $error("timeout not flagged");
	c_seq_end: cover property (@(posedge ref_clk) disable iff (sys_rst)
		s_q.seq == ST_SEND && s_q.idx == SLOW_LAST && !s_d.txv ##1 s_q.seq == ST_IDLE);
	c_fast: cover property (@(posedge ref_clk) disable iff (sys_rst) sync_rx ##[1:3] tx_valid);
	c_fail: cover property (@(posedge ref_clk) disable iff (sys_rst) $rose(comm_fail_q));
endmodule : vnr_responder
`default_nettype wire

// ===== tb/vnr_can_master.sv
// Purpose: far-side consumer of the node's transmit frames
// Assumes: bench itself sends the master's rx traffic
// Notes: random acceptance stalls, only when enabled
`default_nettype none
module vnr_can_master (
	input wire logic ref_clk,
	input wire logic stall_en,
	output logic tx_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	// --------------------------------
	// acceptance
	// --------------------------------
	// a busy bus delays acceptance, so the node must hold its frame
	initial begin
		tx_ready = 1'b1;
		forever begin
			@(negedge ref_clk);
			tx_ready = !stall_en || ($urandom % 3 != 0);
		end
	end
endmodule : vnr_can_master
`default_nettype wire

// ===== tb/vnr_responder_bench.sv
// Purpose: self-checking bench for the valve node tx scheduler
// Assumes: short tick and timeout parameters
// Notes: expected frames queued from a model, popped at acceptance
`default_nettype none
module vnr_responder_bench
	import vnr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int TICK = 20; // shortened slow tick
	localparam int TMO = 200; // shortened link timeout
	logic ref_clk, sys_rst, rx_valid, sync_rx, tx_ready, tx_valid;
	logic params_rx_q, comm_fail_q, stall_en, prev_v, slow_mode;
	logic [6:0] node_id;
	logic [31:0] demand_q;
	logic [63:0] d;
	logic [511:0] rnd;
	vnr_frame_s rx_frame, tx_frame;
	vnr_status_s status;
	vnr_frame_s exp_q[$]; // frames still owed by the design
	int error_cnt, total_checks, cyc, last_rise, slow_n;
	vnr_responder #(.TICK_CYC(TICK), .TMO_CYC(TMO)) i_vnr_responder (.ref_clk(ref_clk),
		.sys_rst(sys_rst), .node_id(node_id), .rx_valid(rx_valid), .rx_frame(rx_frame),
		.sync_rx(sync_rx), .status(status), .tx_ready(tx_ready), .tx_valid(tx_valid),
		.tx_frame(tx_frame), .demand_q(demand_q), .params_rx_q(params_rx_q),
		.comm_fail_q(comm_fail_q));
	vnr_can_master i_vnr_can_master (.ref_clk(ref_clk), .stall_en(stall_en),
		.tx_ready(tx_ready));
	// --------------------------------
	// helpers
	// --------------------------------
	task automatic chk(string nm, logic [78:0] e, logic [78:0] s);
		total_checks++;
		if (s !== e) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	// one rx pulse, sync or frame
	task automatic rx(logic [10:0] base, logic [63:0] dat, logic s);
		@(negedge ref_clk);
		rx_valid = !s;
		sync_rx = s;
		rx_frame = '{base + 11'(node_id), FULL_DLC, dat};
		@(negedge ref_clk);
		rx_valid = 1'b0;
		sync_rx = 1'b0;
	endtask : rx
	// bounded wait until every owed frame is taken
	task automatic drain;
		for (int i = 0; i < 3000 && (exp_q.size() != 0 || tx_valid); i++) @(negedge ref_clk);
		chk("frames owed", 0, exp_q.size());
	endtask : drain
	task automatic new_status;
		for (int i = 0; i < 16; i++) rnd = {rnd[479:0], $urandom};
		status = rnd[$bits(vnr_status_s)-1:0];
	endtask : new_status
	function automatic vnr_frame_s slow_exp(int i);
		logic [10:0] b[7] = '{ID_TEMP, ID_VOLT, ID_POS, ID_CURF, ID_FLG0, ID_FLG4, ID_FLG8};
		logic [63:0] v[7];
		v = '{{status.in_cur, status.drv_temp}, {status.in_v2, status.in_v1},
			{status.pos2, status.pos1}, {32'h0, status.cur_filt},
			{status.flags[3], status.flags[2], status.flags[1], status.flags[0]},
			{16'h0, status.flags[13], status.flags[5], status.flags[4]},
			{16'h0, status.flags[10], status.flags[9], status.flags[8]}};
		return '{b[i] + 11'(node_id), FULL_DLC, v[i]};
	endfunction : slow_exp
	// fast request then sync, owed fast pdo queued
	task automatic fast_round;
		d = {$urandom, $urandom};
		rx(ID_RX_FAST, d, 1'b0);
		exp_q.push_back('{ID_FAST + 11'(node_id), FAST_DLC,
			{26'h0, status.stat, status.act_cur, status.act_pos}});
		rx(11'h0, 64'h0, 1'b1);
	endtask : fast_round
	task automatic print_verdict;
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : print_verdict
	// --------------------------------
	// clock, monitor, watchdog
	// --------------------------------
	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	// every accepted frame must be one the model owes
	always @(posedge ref_clk) begin
		cyc++;
		// rising edge of valid against the value one edge back
		if (slow_mode && tx_valid && !prev_v) begin
			if (slow_n > 0) chk("slow spacing", 1, (cyc - last_rise) >= TICK);
			last_rise = cyc;
			slow_n++;
		end
		prev_v = tx_valid;
		if (tx_valid && tx_ready) begin
			if (exp_q.size() == 0) chk("unexpected tx", 0, tx_frame);
			else chk("tx frame", exp_q.pop_front(), tx_frame);
		end
	end
	initial begin
		#100us;
		error_cnt++;
		print_verdict();
	end
	// --------------------------------
	// tests
	// --------------------------------
	initial begin
		{sys_rst, rx_valid, sync_rx, stall_en, slow_mode} = 5'h10;
		rx_frame = '0;
		void'($urandom(49));
		node_id = 7'($urandom_range(127, 1));
		new_status();
		repeat (12) @(negedge ref_clk);
		sys_rst = 1'b0;
		chk("params at start", 0, params_rx_q);
		repeat (40) @(negedge ref_clk);
		for (int k = 0; k < 4; k++) begin
			stall_en = k[0];
			fast_round();
			drain();
			chk("demand", d[31:0], demand_q);
		end
		// sdo writes with random index and sub-index
		for (int k = 0; k < 3; k++) begin
			d = {$urandom, $urandom};
			d[7:0] = 8'h23;
			rx(ID_SDO_RX, d, 1'b0);
			exp_q.push_back('{ID_SDO_TX + 11'(node_id), FULL_DLC,
				{SDO_ERR_RO, d[31:8], SDO_ABORT_CS}});
			drain();
		end
		// slow sequence with stalls and an extra slow request mid-way
		new_status();
		// a later slow parameter alone sets params but must start nothing
		rx(11'h400, {$urandom, $urandom}, 1'b0);
		repeat (2 * TICK) @(negedge ref_clk);
		chk("params early", 1, params_rx_q);
		chk("slow before first", 0, tx_valid);
		slow_mode = 1'b1;
		stall_en = 1'b1;
		rx(ID_RX_SLOW1, {$urandom, $urandom}, 1'b0);
		for (int i = 0; i < 7; i++) exp_q.push_back(slow_exp(i));
		repeat (2 * TICK) @(negedge ref_clk);
		rx(ID_RX_SLOW1, {$urandom, $urandom}, 1'b0);
		drain();
		chk("slow count", 7, slow_n);
		chk("params seen", 1, params_rx_q);
		{slow_mode, stall_en} = 2'b00;
		// silence, then steady traffic
		repeat (2 * TMO + 10) @(negedge ref_clk);
		chk("comm fail set", 1, comm_fail_q);
		for (int k = 0; k < 14; k++) begin
			fast_round();
			repeat (30) @(negedge ref_clk);
		end
		drain();
		chk("comm fail clear", 0, comm_fail_q);
		print_verdict();
	end
endmodule : vnr_responder_bench
`default_nettype wire
